// ---- rtl/rstc_defines.svh ----
/*
   Constants for the reset timeout and reset-cause block: register indices,
   field positions, reset values and timing counts.
   Assumes a 125 MHz pclk that also serves as the oscillator period reference.
*/
`ifndef RSTC_DEFINES_SVH
`define RSTC_DEFINES_SVH

// register indices, byte address is four times the index
`define RSTC_IDX_STATUS 10'h003
`define RSTC_IDX_POWER_CONTROL_FLAGS 10'h08e
`define RSTC_IDX_CFG 10'h090
`define RSTC_IDX_EVT 10'h091
`define RSTC_IDX_MASK 10'h092
`define RSTC_IDX_SEQ 10'h093

// status register fields
`define RSTC_ST_BANK 7:5
`define RSTC_ST_TO 4
`define RSTC_ST_PD 3
`define RSTC_ST_SW_MASK 8'he7

// power control register fields
`define RSTC_PC_OSC_SPEED_SELECT 3
`define RSTC_PC_POR 1
`define RSTC_PC_BOR 0
`define RSTC_PC_WR_MASK 8'h0b

// config register fields
`define RSTC_CFG_MODE 2:0
`define RSTC_CFG_POWER_UP_DELAY_DISABLE 4
`define RSTC_CFG_BROWNOUT_DETECT_ENABLE 5
`define RSTC_CFG_GIE 6
`define RSTC_CFG_WR_MASK 8'h77

// reset values
`define RSTC_STATUS_POR 8'h18
`define RSTC_POWER_CONTROL_FLAGS_POR 8'h08
`define RSTC_CFG_RST 8'h24
`define RSTC_EVT_RST 7'h01
`define RSTC_EVT_W 7

// program counter vectors
`define RSTC_RESET_VEC 13'h000
`define RSTC_IRQ_VEC 13'h004

// timing
`define RSTC_CLK_MHZ 125
`define RSTC_POWER_UP_DELAY_TIMER_MS 72
`define RSTC_POWER_UP_DELAY_TIMER_CYCLES (`RSTC_POWER_UP_DELAY_TIMER_MS * 1000 * `RSTC_CLK_MHZ)
`define RSTC_OST_PERIODS 1024
`define RSTC_OST_CYCLES 24'd1024
`define RSTC_WAKE_NS 6000
`define RSTC_WAKE_CYCLES ((`RSTC_WAKE_NS * `RSTC_CLK_MHZ + 999) / 1000)
`define RSTC_TMR_W 24

`endif

// ---- rtl/rstc_pkg.sv ----
/*
   Types shared by the reset timeout and reset-cause block.
   Assumes nothing beyond a SystemVerilog compiler.
*/
package rstc_pkg;

   // oscillator modes as held in the config register
   typedef enum logic [2:0] {
      OSC_CRYSTAL_LOW_POWER,
      OSC_CRYSTAL_MEDIUM,
      OSC_CRYSTAL_HIGH_SPEED,
      OSC_EXTERNAL_CLOCK,
      OSC_INTERNAL,
      OSC_RESISTOR_CAPACITOR
   } rstc_osc_t;

   // reset sequencer states
   typedef enum logic [2:0] {
      ST_HOLD,
      ST_POWER_UP_DELAY_TIMER,
      ST_OST,
      ST_WAIT_PIN,
      ST_RUN,
      ST_SLEEP,
      ST_WAKE
   } rstc_state_t;

endpackage

// ---- rtl/rstc_tmr_if.sv ----
/*
   Handshake between the sequencer and one timeout counter.
   Assumes both ends run on pclk.
*/
`timescale 1ns/1ns
interface rstc_tmr_if #(parameter int W = 24);
   logic start;
   logic [W-1:0] limit;
   logic done;
   logic busy;

   modport timer (input start, input limit, output done, output busy);
   modport ctrl (output start, output limit, input done, input busy);
endinterface

// ---- rtl/rstc_timer.sv ----
/*
   Down counter for one timeout: start loads the limit, done pulses once
   after that many clocks. A new start restarts it at any time.
   Assumes limit is at least one while start is high.
*/
`timescale 1ns/1ns
module rstc_timer #(
   parameter int W = 24
) (
   input wire logic pclk,
   input wire logic presetn,
   rstc_tmr_if.timer t
);

   logic [W-1:0] cnt_ff;
   logic busy_ff;
   logic done_ff;

   assign t.done = done_ff;
   assign t.busy = busy_ff;

   // count down, pulse done on the last count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= '0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         if (t.start) begin
            cnt_ff <= t.limit;
            busy_ff <= 1'b1;
         end else if (busy_ff) begin
            if (cnt_ff <= W'(1)) begin
               busy_ff <= 1'b0;
               done_ff <= 1'b1;
            end else begin
               cnt_ff <= cnt_ff - W'(1);
            end
         end
      end
   end

endmodule

// ---- rtl/rstc_top.sv ----
/*
   Reset timeout sequencer and reset-cause flags, reached over APB.
   Holds the core in reset through the power-up delay and oscillator start-up,
   keeps the status and power control flags per reset cause, and tells the
   core where to resume. Assumes all inputs synchronous to pclk and
   por_pulse high while power-on detection is active.
*/
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
`include "rstc_defines.svh"
module rstc_top import rstc_pkg::*; #(
   parameter int POWER_UP_DELAY_TIMER_CYCLES = `RSTC_POWER_UP_DELAY_TIMER_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic por_pulse,
   input wire logic brownout_det,
   input wire logic external_reset_pin_n,
   input wire logic watchdog_timeout,
   input wire logic sleep_enter,
   input wire logic irq_wake,
   output logic core_reset_n,
   output logic pc_load,
   output logic pc_incr,
   output logic [12:0] pc_addr,
   output logic irq
);

   rstc_state_t state_ff;
   rstc_state_t nxt_state;
   logic [7:0] status_ff;
   logic [7:0] nxt_status;
   logic [7:0] power_control_flags_ff;
   logic [7:0] nxt_power_control_flags;
   logic [7:0] cfg_ff;
   logic [`RSTC_EVT_W-1:0] evt_ff;
   logic [`RSTC_EVT_W-1:0] nxt_evt;
   logic [`RSTC_EVT_W-1:0] mask_ff;
   logic por_q_ff;
   logic bor_q_ff;
   logic wake_irq_ff;
   logic core_reset_n_ff;
   logic pc_load_ff;
   logic pc_incr_ff;
   logic [12:0] pc_addr_ff;
   logic irq_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;

   rstc_tmr_if #(.W(`RSTC_TMR_W)) power_up_delay_timer_if ();
   rstc_tmr_if #(.W(`RSTC_TMR_W)) ost_if ();

   // power-up delay counter
   rstc_timer #(.W(`RSTC_TMR_W)) u_power_up_delay_timer (
      .pclk(pclk),
      .presetn(presetn),
      .t(power_up_delay_timer_if.timer)
   );

   // oscillator start-up and wake counter
   rstc_timer #(.W(`RSTC_TMR_W)) u_ost (
      .pclk(pclk),
      .presetn(presetn),
      .t(ost_if.timer)
   );

   // configuration decode
   wire rstc_osc_t osc_mode = rstc_osc_t'(cfg_ff[`RSTC_CFG_MODE]);
   wire is_crystal = (osc_mode == OSC_CRYSTAL_LOW_POWER) ||
                     (osc_mode == OSC_CRYSTAL_MEDIUM) ||
                     (osc_mode == OSC_CRYSTAL_HIGH_SPEED);
   wire is_internal_osc_mode = (osc_mode == OSC_INTERNAL);
   wire power_up_delay_timer_en = !cfg_ff[`RSTC_CFG_POWER_UP_DELAY_DISABLE];
   wire brownout_detect_enable = cfg_ff[`RSTC_CFG_BROWNOUT_DETECT_ENABLE];
   wire global_irq_enable = cfg_ff[`RSTC_CFG_GIE];

   // reset and wake causes, highest priority first
   wire bor_act = brownout_det && brownout_detect_enable && !por_pulse;
   wire hold_now = por_pulse || bor_act;
   wire in_run = (state_ff == ST_RUN);
   wire in_sleep = (state_ff == ST_SLEEP);
   wire ext_rst = !external_reset_pin_n && (in_run || in_sleep) && !hold_now;
   wire ext_sleep = ext_rst && in_sleep;
   wire wdt_rst = watchdog_timeout && in_run && !hold_now && !ext_rst;
   wire wdt_wake = watchdog_timeout && in_sleep && !hold_now && !ext_rst;
   wire irq_wk = irq_wake && in_sleep && !hold_now && !ext_rst && !watchdog_timeout;
   wire sleep_go = sleep_enter && in_run && !hold_now && !ext_rst && !wdt_rst;
   wire wake_any = wdt_wake || irq_wk;
   wire wake_timed = is_crystal || is_internal_osc_mode;
   wire ev_por = por_pulse && !por_q_ff;
   wire ev_bor = bor_act && !bor_q_ff;

   // sequencer next state
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_HOLD: begin
            if (power_up_delay_timer_en) begin
               nxt_state = ST_POWER_UP_DELAY_TIMER;
            end else if (is_crystal) begin
               nxt_state = ST_OST;
            end else begin
               nxt_state = ST_WAIT_PIN;
            end
         end
         ST_POWER_UP_DELAY_TIMER: begin
            if (power_up_delay_timer_if.done) begin
               nxt_state = is_crystal ? ST_OST : ST_WAIT_PIN;
            end
         end
         ST_OST: begin
            if (ost_if.done) begin
               nxt_state = ST_WAIT_PIN;
            end
         end
         ST_WAIT_PIN: begin
            if (external_reset_pin_n) begin
               nxt_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (ext_rst || wdt_rst) begin
               nxt_state = ST_WAIT_PIN;
            end else if (sleep_go) begin
               nxt_state = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (ext_rst) begin
               nxt_state = ST_WAIT_PIN;
            end else if (wake_any) begin
               nxt_state = wake_timed ? ST_WAKE : ST_RUN;
            end
         end
         ST_WAKE: begin
            if (ost_if.done) begin
               nxt_state = ST_RUN;
            end
         end
      endcase
      if (hold_now) begin
         nxt_state = ST_HOLD;
      end
   end

   // timer starts on entry to a timed state, restart re-initialises the delay
   assign power_up_delay_timer_if.start = (nxt_state == ST_POWER_UP_DELAY_TIMER) && (state_ff != ST_POWER_UP_DELAY_TIMER);
   assign power_up_delay_timer_if.limit = `RSTC_TMR_W'(POWER_UP_DELAY_TIMER_CYCLES);
   assign ost_if.start = ((nxt_state == ST_OST) && (state_ff != ST_OST)) ||
                         ((nxt_state == ST_WAKE) && (state_ff != ST_WAKE));
   assign ost_if.limit = (in_sleep && is_internal_osc_mode) ?
                         `RSTC_TMR_W'(`RSTC_WAKE_CYCLES) : `RSTC_OST_CYCLES;

   wire release_rst = (state_ff == ST_WAIT_PIN) && (nxt_state == ST_RUN);
   wire wake_done = (in_sleep || state_ff == ST_WAKE) && (nxt_state == ST_RUN);
   wire nxt_core = (nxt_state == ST_RUN) || (nxt_state == ST_SLEEP) ||
                   (nxt_state == ST_WAKE);

   // apb decode
   wire acc = psel && penable;
   wire rd_load = acc && !pready_ff;
   wire wr_en = acc && pwrite && pready_ff;
   wire [9:0] idx = paddr[11:2];
   wire hit_status = (idx == `RSTC_IDX_STATUS);
   wire hit_power_control_flags = (idx == `RSTC_IDX_POWER_CONTROL_FLAGS);
   wire hit_cfg = (idx == `RSTC_IDX_CFG);
   wire hit_evt = (idx == `RSTC_IDX_EVT);
   wire hit_mask = (idx == `RSTC_IDX_MASK);
   wire hit_seq = (idx == `RSTC_IDX_SEQ);
   wire mapped = hit_status || hit_power_control_flags || hit_cfg || hit_evt || hit_mask || hit_seq;
   wire [7:0] wbyte = pwdata[7:0];
   wire [31:0] rd_mux = hit_status ? {24'h0, status_ff} :
                        hit_power_control_flags ? {24'h0, power_control_flags_ff} :
                        hit_cfg ? {24'h0, cfg_ff} :
                        hit_evt ? {25'h0, evt_ff} :
                        hit_mask ? {25'h0, mask_ff} :
                        hit_seq ? {27'h0, core_reset_n_ff, 1'b0, state_ff} : 32'h0;

   // status flags: software bits first, hardware causes override
   always_comb begin
      nxt_status = status_ff;
      if (wr_en && hit_status) begin
         nxt_status = (status_ff & ~`RSTC_ST_SW_MASK) | (wbyte & `RSTC_ST_SW_MASK);
      end
      if (por_pulse) begin
         nxt_status = `RSTC_STATUS_POR;
      end else if (bor_act) begin
         nxt_status[`RSTC_ST_BANK] = 3'h0;
         nxt_status[`RSTC_ST_TO] = 1'b1;
         nxt_status[`RSTC_ST_PD] = 1'b1;
      end else if (ext_sleep) begin
         nxt_status[`RSTC_ST_BANK] = 3'h0;
         nxt_status[`RSTC_ST_TO] = 1'b1;
         nxt_status[`RSTC_ST_PD] = 1'b0;
      end else if (ext_rst) begin
         nxt_status[`RSTC_ST_BANK] = 3'h0;
      end else if (wdt_rst) begin
         nxt_status[`RSTC_ST_BANK] = 3'h0;
         nxt_status[`RSTC_ST_TO] = 1'b0;
      end else if (wdt_wake) begin
         nxt_status[`RSTC_ST_TO] = 1'b0;
         nxt_status[`RSTC_ST_PD] = 1'b0;
      end else if (irq_wk || sleep_go) begin
         nxt_status[`RSTC_ST_TO] = 1'b1;
         nxt_status[`RSTC_ST_PD] = 1'b0;
      end
   end

   // power control flags: only the three flag bits take writes
   always_comb begin
      nxt_power_control_flags = power_control_flags_ff;
      if (wr_en && hit_power_control_flags) begin
         nxt_power_control_flags = (power_control_flags_ff & ~`RSTC_PC_WR_MASK) | (wbyte & `RSTC_PC_WR_MASK);
      end
      if (por_pulse) begin
         nxt_power_control_flags = `RSTC_POWER_CONTROL_FLAGS_POR;
      end else if (bor_act) begin
         nxt_power_control_flags[`RSTC_PC_OSC_SPEED_SELECT] = 1'b1;
         nxt_power_control_flags[`RSTC_PC_BOR] = 1'b0;
      end else if (ext_rst || wdt_rst) begin
         nxt_power_control_flags[`RSTC_PC_OSC_SPEED_SELECT] = 1'b1;
      end
   end

   // sticky cause bits: a new event wins over a write-one clear
   always_comb begin
      nxt_evt = evt_ff;
      if (wr_en && hit_evt) begin
         nxt_evt = evt_ff & ~wbyte[`RSTC_EVT_W-1:0];
      end
      nxt_evt = nxt_evt | {release_rst, irq_wk, wdt_wake, wdt_rst, ext_rst, ev_bor, ev_por};
   end

   // sequencer and flag registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ST_HOLD;
         status_ff <= `RSTC_STATUS_POR;
         power_control_flags_ff <= `RSTC_POWER_CONTROL_FLAGS_POR;
         evt_ff <= `RSTC_EVT_RST;
         por_q_ff <= 1'b0;
         bor_q_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         status_ff <= nxt_status;
         power_control_flags_ff <= nxt_power_control_flags;
         evt_ff <= nxt_evt;
         por_q_ff <= por_pulse;
         bor_q_ff <= bor_act;
      end
   end

   // software-owned config and mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_ff <= `RSTC_CFG_RST;
         mask_ff <= '0;
      end else begin
         if (wr_en && hit_cfg) begin
            cfg_ff <= wbyte & `RSTC_CFG_WR_MASK;
         end
         if (wr_en && hit_mask) begin
            mask_ff <= wbyte[`RSTC_EVT_W-1:0];
         end
      end
   end

   // core reset and resume address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_reset_n_ff <= 1'b0;
         pc_load_ff <= 1'b0;
         pc_incr_ff <= 1'b0;
         pc_addr_ff <= `RSTC_RESET_VEC;
         wake_irq_ff <= 1'b0;
      end else begin
         core_reset_n_ff <= nxt_core;
         pc_load_ff <= release_rst || (wake_done && wake_irq_ff && global_irq_enable);
         pc_incr_ff <= wake_done;
         if (release_rst) begin
            pc_addr_ff <= `RSTC_RESET_VEC;
         end else if (wake_done) begin
            pc_addr_ff <= `RSTC_IRQ_VEC;
         end
         if (wake_any) begin
            wake_irq_ff <= irq_wk;
         end
      end
   end

   // apb answer one cycle into the access phase; interrupt level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         prdata_ff <= 32'h0;
         pslverr_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         pready_ff <= rd_load;
         prdata_ff <= rd_load ? rd_mux : 32'h0;
         pslverr_ff <= rd_load && !mapped;
         irq_ff <= |(nxt_evt & mask_ff);
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign core_reset_n = core_reset_n_ff;
   assign pc_load = pc_load_ff;
   assign pc_incr = pc_incr_ff;
   assign pc_addr = pc_addr_ff;
   assign irq = irq_ff;

endmodule

// ---- dv/rstc_far_model.sv ----
/* far-side model: supply monitors, external reset pin and core event pulses.
   assumes the bench calls its tasks from one process at a time. */
`timescale 1ns/1ns
module rstc_far_model (
   input wire logic pclk,
   output logic por_pulse,
   output logic brownout_det,
   output logic external_reset_pin_n,
   output logic watchdog_timeout,
   output logic sleep_enter,
   output logic irq_wake
);
   // active sources: 0 power-on, 1 brown-out, 2 pin, 3 watchdog, 4 sleep, 5 irq
   logic [5:0] act = 6'h01;

   // pin is active low and idles high on its pull-up
   assign {irq_wake, sleep_enter, watchdog_timeout} = act[5:3];
   assign external_reset_pin_n = ~act[2];
   assign {brownout_det, por_pulse} = act[1:0];

   // raise one source for n cycles, changes land just after an edge
   task automatic drive(input int k, input int n);
      @(posedge pclk);
      act[k] <= 1'b1;
      repeat (n) @(posedge pclk);
      act[k] <= 1'b0;
   endtask

   // hold one source at a level, used to keep the pin low past the timeouts
   task automatic hold(input int k, input logic v);
      @(posedge pclk);
      act[k] <= v;
   endtask
endmodule

// ---- dv/rstc_top_assertions.sv ----
/* assertions on rstc_top ports: apb answer timing and core release.
   assumes a bind into rstc_top and a single pclk domain. */
`timescale 1ns/1ns
module rstc_chk #(
   parameter int POWER_UP_DELAY_TIMER_CYCLES = 20
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic por_pulse,
   input wire logic external_reset_pin_n,
   input wire logic core_reset_n,
   input wire logic pc_load,
   input wire logic pc_incr,
   input wire logic [12:0] pc_addr
);
   // one domain, all checks quiet in reset
   default clocking dck @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // apb: one wait state, answer stands one cycle
   wait_state_a: assert property (psel && penable && !pready |=> pready)
      else $error("apb answer late");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held");
   err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("bad error answer");

   // core held while a cause is active
   por_hold_a: assert property (por_pulse [*2] |-> !core_reset_n)
      else $error("core runs during power-on");
   pin_hold_a: assert property (!external_reset_pin_n [*3] |-> !core_reset_n)
      else $error("core runs with pin low");
   pin_gate_a: assert property ($rose(core_reset_n) |-> $past(external_reset_pin_n))
      else $error("release with pin low");

   // program counter control on release and wake
   release_vec_a: assert property (
      $rose(core_reset_n) |-> pc_load && !pc_incr && pc_addr == 13'h000)
      else $error("release without reset vector");
   load_run_a: assert property (pc_load || pc_incr |-> core_reset_n)
      else $error("pc control during reset");
   wake_vec_a: assert property (pc_load && pc_incr |-> pc_addr == 13'h004)
      else $error("interrupt wake without vector");
endmodule

bind rstc_top rstc_chk #(.POWER_UP_DELAY_TIMER_CYCLES(POWER_UP_DELAY_TIMER_CYCLES)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .por_pulse(por_pulse),
   .external_reset_pin_n(external_reset_pin_n), .core_reset_n(core_reset_n),
   .pc_load(pc_load), .pc_incr(pc_incr), .pc_addr(pc_addr)
);

// ---- dv/testbench.sv ----
/* bench for rstc_top: register rows, timeouts per mode, reset causes,
   wake paths and interrupt. assumes rstc_far_model and the bound checker. */
`timescale 1ns/1ns
`include "rstc_defines.svh"
module testbench;
   localparam int PW = 20;
   localparam logic [11:0] STA = 12'(`RSTC_IDX_STATUS * 4);
   localparam logic [11:0] PCN = 12'(`RSTC_IDX_POWER_CONTROL_FLAGS * 4);
   localparam logic [11:0] CFG = 12'(`RSTC_IDX_CFG * 4);
   localparam logic [11:0] EVT = 12'(`RSTC_IDX_EVT * 4);
   localparam logic [11:0] MSK = 12'(`RSTC_IDX_MASK * 4);
   localparam logic [11:0] SEQ = 12'(`RSTC_IDX_SEQ * 4);
   typedef struct packed {
      logic w;
      logic [11:0] a;
      logic [7:0] d;
      logic [7:0] e;
      logic er;
   } rstc_row_t;
   // rows: write, address, data, expected read, expected error
   localparam rstc_row_t ROWS [14] = '{
      '{1'b0, PCN, 8'h00, 8'h08, 1'b0},
      '{1'b1, PCN, 8'hff, 8'h00, 1'b0},
      '{1'b0, PCN, 8'h00, 8'h0b, 1'b0},
      '{1'b1, PCN, 8'h00, 8'h00, 1'b0},
      '{1'b0, PCN, 8'h00, 8'h00, 1'b0},
      '{1'b1, STA, 8'h00, 8'h00, 1'b0},
      '{1'b0, STA, 8'h00, 8'h18, 1'b0},
      '{1'b0, CFG, 8'h00, 8'h24, 1'b0},
      '{1'b0, SEQ, 8'h00, 8'h14, 1'b0},
      '{1'b0, EVT, 8'h00, 8'h41, 1'b0},
      '{1'b1, EVT, 8'h41, 8'h00, 1'b0},
      '{1'b0, EVT, 8'h00, 8'h00, 1'b0},
      '{1'b1, 12'h400, 8'hff, 8'h00, 1'b1},
      '{1'b0, 12'h400, 8'h00, 8'h00, 1'b1}};

   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, por_pulse, brownout_det, pin_n, wdt, slp, irqw, irq;
   logic core_reset_n, pc_load, pc_incr, inc_ld;
   logic [12:0] pc_addr, ld_addr;
   int ld_cnt = 0;
   int inc_cnt = 0;
   int error_cnt = 0;
   int n_compared = 0;

   rstc_top #(.POWER_UP_DELAY_TIMER_CYCLES(PW)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .por_pulse(por_pulse), .brownout_det(brownout_det), .external_reset_pin_n(pin_n),
      .watchdog_timeout(wdt), .sleep_enter(slp), .irq_wake(irqw),
      .core_reset_n(core_reset_n), .pc_load(pc_load), .pc_incr(pc_incr),
      .pc_addr(pc_addr), .irq(irq));
   rstc_far_model far (
      .pclk(pclk), .por_pulse(por_pulse), .brownout_det(brownout_det),
      .external_reset_pin_n(pin_n), .watchdog_timeout(wdt), .sleep_enter(slp),
      .irq_wake(irqw));

   // 125 MHz clock
   initial begin
      forever #4 pclk = ~pclk;
   end

   // log of program counter loads and advances
   always @(posedge pclk) begin
      if (pc_load === 1'b1) begin
         ld_cnt++;
         ld_addr = pc_addr;
      end
      if (pc_incr === 1'b1) begin
         inc_cnt++;
         inc_ld = pc_load;
      end
   end

   task automatic fail(input string m);
      error_cnt++;
      $display("Error %0t: %s", $time, m);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp) fail($sformatf("%s got %h expected %h", m, got, exp));
   endtask

   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // one apb transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                      output logic [31:0] rd, output logic er);
      int t = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 20);
      if (t == 20) fail("apb answer missing");
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      logic [31:0] v;
      logic er;
      apb(1'b0, a, 8'h00, v, er);
      chk(v, {24'h0, e}, $sformatf("read %h", a));
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] v;
      logic er;
      apb(1'b1, a, d, v, er);
   endtask

   // wait for release (0), a load (1) or an advance (2); n counts cycles
   task automatic wait_ev(input int k, output int n);
      int c0 = ld_cnt;
      int c1 = inc_cnt;
      n = 0;
      while (n < 3000 && (k == 0 ? core_reset_n !== 1'b1 :
                          k == 1 ? ld_cnt == c0 : inc_cnt == c1)) begin
         @(posedge pclk);
         n++;
      end
      if (n == 3000) fail("event wait timed out");
   endtask

   // power-on pulse, then release time against the expected count
   task automatic boot(input int e);
      int n;
      far.drive(0, 3);
      wait_ev(0, n);
      chk(32'(n >= e && n <= e + 6), 32'h1, $sformatf("release after %0d", n));
   endtask

   task automatic done(input string m);
      $display("test %s finished", m);
   endtask

   initial begin
      int n;
      int c;
      logic [31:0] v;
      logic er;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      boot(PW);
      foreach (ROWS[i]) begin
         apb(ROWS[i].w, ROWS[i].a, ROWS[i].d, v, er);
         if (!ROWS[i].w) chk(v, {24'h0, ROWS[i].e}, "row read");
         chk(32'(er), 32'(ROWS[i].er), "row error");
      end
      done("registers");
      for (int m = 0; m < 6; m++) begin
         for (int p = 0; p < 2; p++) begin
            wr(CFG, 8'h20 | 8'(p * 16 + m));
            boot((m < 3 ? 1024 : 0) + (p == 1 ? 0 : PW));
            rd(STA, 8'h18);
            rd(PCN, 8'h08);
         end
      end
      done("timeouts");
      wr(CFG, 8'h21);
      far.hold(2, 1'b1);
      far.drive(0, 3);
      repeat (PW + 1100) @(posedge pclk);
      chk(32'(core_reset_n), 32'h0, "held by pin");
      far.hold(2, 1'b0);
      wait_ev(0, n);
      chk(32'(n <= 3), 32'h1, "release on pin");
      done("pin");
      wr(CFG, 8'h24);
      wr(PCN, 8'h03);
      wr(STA, 8'he5);
      far.drive(1, 4);
      wait_ev(0, n);
      chk(32'(n >= PW && n <= PW + 6), 32'h1, "brown-out delay");
      rd(PCN, 8'h0a);
      rd(STA, 8'h1d);
      wr(CFG, 8'h04);
      wr(PCN, 8'h03);
      far.drive(1, 4);
      chk(32'(core_reset_n), 32'h1, "detector off");
      rd(PCN, 8'h03);
      done("brown-out");
      wr(CFG, 8'h24);
      wr(STA, 8'he5);
      far.drive(3, 1);
      wait_ev(1, n);
      chk(32'(ld_addr), 32'h0, "reset vector");
      rd(STA, 8'h0d);
      far.drive(4, 1);
      wr(STA, 8'he5);
      far.drive(2, 4);
      wait_ev(1, n);
      rd(STA, 8'h15);
      wr(STA, 8'he5);
      far.drive(2, 4);
      wait_ev(1, n);
      rd(STA, 8'h15);
      done("watchdog and pin");
      wr(CFG, 8'h21);
      wr(STA, 8'he5);
      far.drive(4, 1);
      c = ld_cnt;
      far.drive(3, 1);
      wait_ev(2, n);
      chk(32'(n >= 1024 && n <= 1030), 32'h1, "crystal wake");
      chk(ld_cnt, c, "load on plain wake");
      rd(STA, 8'he5);
      wr(CFG, 8'h64);
      far.drive(4, 1);
      far.drive(5, 1);
      wait_ev(2, n);
      chk(32'(n >= 750 && n <= 756), 32'h1, "internal wake");
      chk(32'(inc_ld), 32'h1, "load with advance");
      chk(32'(ld_addr), 32'h4, "interrupt vector");
      rd(STA, 8'hf5);
      done("wake");
      wr(EVT, 8'h7f);
      wr(MSK, 8'h08);
      far.drive(3, 1);
      wait_ev(1, n);
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h1, "irq raised");
      wr(MSK, 8'h00);
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h0, "irq masked");
      wr(MSK, 8'h08);
      wr(EVT, 8'h08);
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h0, "irq cleared");
      done("interrupt");
      // mid-run reset: outputs quiet, then a fresh delay without a power-on pulse
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({core_reset_n, pc_load, pc_incr, irq, pready, pslverr}, 32'h0, "outputs in reset");
      chk(32'(pc_addr), 32'h0, "address in reset");
      presetn <= 1'b1;
      wait_ev(0, n);
      chk(32'(n >= PW && n <= PW + 6), 32'h1, "release after reset");
      rd(CFG, 8'h24);
      done("reset");
      close_out();
   end

   // hang guard, well past the expected run length
   initial begin
      repeat (40000) @(posedge pclk);
      fail("watchdog expired");
      close_out();
   end
endmodule
